/* File: common/lws_defs.vh */
// Constants for the list waveform sequencer: register map, fields,
// command codes, reset values and timing.
// Assumes a 32-bit AHB-Lite slave port and a 100 MHz core clock.
`ifndef LWS_DEFS_VH
`define LWS_DEFS_VH

// Register byte offsets
`define LWS_A_TRIG 8'h00
`define LWS_A_CTRL 8'h04
`define LWS_A_COUNT 8'h08
`define LWS_A_SKIP 8'h0c
`define LWS_A_CMD 8'h10
`define LWS_A_CUR 8'h14
`define LWS_A_VOLT 8'h18
`define LWS_A_DWELL 8'h1c
`define LWS_A_RBSTART 8'h20
`define LWS_A_MAINRD 8'h24
`define LWS_A_DWELLRD 8'h28
`define LWS_A_POINTS 8'h2c
`define LWS_A_STATUS 8'h30
`define LWS_A_ERR 8'h34

// Control register fields
`define LWS_B_DIR 0
`define LWS_B_ORDER 1
`define LWS_B_REG 2

// Command codes written to the command register
`define LWS_C_CLEAR 4'h1
`define LWS_C_TRIG 4'h2
`define LWS_C_HALT 4'h3
`define LWS_C_VLIST 4'h4
`define LWS_C_CLIST 4'h5
`define LWS_C_VFIX 4'h6
`define LWS_C_CFIX 4'h7
`define LWS_C_VTRANS 4'h8
`define LWS_C_CTRANS 4'h9
`define LWS_C_SAVE 4'ha
`define LWS_C_RECALL 4'hb

// Source modes
`define LWS_M_SETTING_A 2'h0
`define LWS_M_LIST 2'h1
`define LWS_M_TRANSIENT_SETTING 2'h2

// Reset and clear values
`define LWS_COUNT_RST 8'h01
`define LWS_SKIP_RST 8'h00
`define LWS_PTR_RST 10'h000

// Error code -221 as 16-bit two's complement
`define LWS_ERR_CONFLICT 16'hff23

// Timing: dwell counted in 0.5 ms ticks, from 0.0005 s to 10 s
`define LWS_CLK_NS 10
`define LWS_TICK_NS 500000
`define LWS_DWELL_MIN 15'h0001
`define LWS_DWELL_MAX 15'h4e20
`define LWS_RB_WINDOW 4'hf

`endif

/* File: src/lws_list_sequencer.v */
// List waveform sequencer: stores a main-channel list and dwell list,
// plays it with repeat count, direction and later-pass skip, and holds
// the trigger regulation mode.
// Assumes a single AHB-Lite master on core_clk; all inputs are on the
// same clock, so no synchronisers are needed.
//
// Operation
// [RL1] Trigger applies stored trigger regulation mode
// [RL2] Trigger mode reads 0 voltage, 1 current
// [RL3] Trigger-mode write forces transient sources setting_a
// [RL4] Save and recall keep trigger mode
// [RL5] Clear zeroes pointers, up, default order, count 1
// [RL6] Repeat count 0..255, zero repeats forever
// [RL7] Repeat count reads back last written value
// [RL8] Up plays first to last, down reverse
// [RL9] Later passes omit first n steps
// [RL10] Clear sets skip to zero
// [RL11] Skip ignored when direction is down
// [RL12] Current entries fill consecutive locations, 1002 max
// [RL13] Input limited to 253 characters per command
// [RL14] Voltage entries present flag settings conflict error
// [RL15] Host selects regulation before list entries
// [RL16] Readback returns up to 16 values from start
// [RL17] Current pointer counts stored points from zero
// [RL18] Dwell 0.0005 to 10 s per location
// [RL19] Single dwell at location 0 applies to all
// [RL20] List source mode starts playback
// [RL21] Finished list holds last step value
// [RL22] Dwell timer resolves 0.5 ms exactly
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "lws_defs.vh"

module lws_list_sequencer
#(
	parameter LIST_DEPTH = 1002,
	parameter TICK_CYC = `LWS_TICK_NS / `LWS_CLK_NS
)
(
	input wire core_clk,
	input wire resetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	output reg [31:0] setpoint_q,
	output wire regulation_current,
	output wire list_running,
	output wire [1:0] voltage_source_mode,
	output wire [1:0] current_source_mode
);

	localparam S_IDLE = 3'b001;
	localparam S_STEP = 3'b010;
	localparam S_HOLD = 3'b100;
	localparam [31:0] TICK_SPAN = TICK_CYC - 1;
	localparam [16:0] TICK_LAST = TICK_SPAN[16:0];

	// Register hit in the data phase of a transfer
	function hit;
		input en;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = en && (a == off);
		end
	endfunction

	reg wr_q, rd_q;
	reg [7:0] addr_q;
	reg trig_reg_q, saved_trig_q, regulation_q, dir_down_q, order_user_q;
	reg [7:0] count_q, skip_q, err_cnt_q, pass_q;
	reg [1:0] vmode_q, cmode_q;
	reg [9:0] cur_ptr_q, volt_ptr_q, dwell_ptr_q, rb_start_q, pos_q;
	reg [3:0] rb_idx_q;
	reg [2:0] state_q;
	reg [16:0] tick_q;
	reg [14:0] hold_q;
	reg [31:0] main_mem [0:LIST_DEPTH-1];
	reg [14:0] dwell_mem [0:LIST_DEPTH-1];

	// Address phase capture; one transfer is pending at most
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= 8'h00;
		end
		else if (hready)
		begin
			wr_q <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
			rd_q <= hsel && htrans[1] && !hwrite;
			addr_q <= haddr[7:0];
		end
	end

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	wire cmd_ev = hit(wr_q, addr_q, `LWS_A_CMD);
	wire [3:0] cmd = hwdata[3:0];
	wire do_clear = cmd_ev && (cmd == `LWS_C_CLEAR);
	wire do_trig = cmd_ev && (cmd == `LWS_C_TRIG);
	wire do_halt = cmd_ev && (cmd == `LWS_C_HALT);
	wire v_list = cmd_ev && (cmd == `LWS_C_VLIST);
	wire c_list = cmd_ev && (cmd == `LWS_C_CLIST);
	wire v_fix = cmd_ev && (cmd == `LWS_C_VFIX);
	wire c_fix = cmd_ev && (cmd == `LWS_C_CFIX);
	wire trig_wr = hit(wr_q, addr_q, `LWS_A_TRIG);
	wire volt_busy = (volt_ptr_q != `LWS_PTR_RST);
	wire cur_wr = hit(wr_q, addr_q, `LWS_A_CUR);
	wire volt_wr = hit(wr_q, addr_q, `LWS_A_VOLT);
	wire dwell_wr = hit(wr_q, addr_q, `LWS_A_DWELL);
	wire main_rd = hit(rd_q, addr_q, `LWS_A_MAINRD);
	wire dwell_rd = hit(rd_q, addr_q, `LWS_A_DWELLRD);
	wire pts_rd = hit(rd_q, addr_q, `LWS_A_POINTS);
	wire err_rd = hit(rd_q, addr_q, `LWS_A_ERR);

	// Each write carries one value, so the 253-character limit never binds
	wire cur_ok = cur_wr && !volt_busy && (cur_ptr_q < LIST_DEPTH); // see [RL13]
	wire volt_ok = volt_wr && (cur_ptr_q == `LWS_PTR_RST) && (volt_ptr_q < LIST_DEPTH);
	wire dwell_ok = dwell_wr && (dwell_ptr_q < LIST_DEPTH);
	wire err_set = volt_busy && (cur_wr || main_rd || pts_rd); // see [RL14]

	// Main channel holds whichever list was entered; lengths share it
	wire [9:0] len = volt_busy ? volt_ptr_q : cur_ptr_q;
	wire [9:0] last_pos = len - 10'h001;
	wire stop_play = do_halt || do_clear || v_fix || c_fix; // see [RL6]
	wire start_play = (v_list || c_list) && (len != `LWS_PTR_RST); // see [RL20]

	// Dwell clamped into the 0.5 ms tick range
	wire [14:0] dwell_in = (hwdata[31:15] != 17'h00000) ? `LWS_DWELL_MAX :
		(hwdata[14:0] < `LWS_DWELL_MIN) ? `LWS_DWELL_MIN :
		(hwdata[14:0] > `LWS_DWELL_MAX) ? `LWS_DWELL_MAX : hwdata[14:0]; // see [RL18]

	// List storage, no reset: contents are only valid below the pointers
	always @(posedge core_clk)
	begin
		if (cur_ok)
			main_mem[cur_ptr_q] <= hwdata; // see [RL12]
		else if (volt_ok)
			main_mem[volt_ptr_q] <= hwdata;
		if (dwell_ok)
			dwell_mem[dwell_ptr_q] <= dwell_in;
	end

	// Settings, pointers and source modes
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			trig_reg_q <= 1'b0;
			saved_trig_q <= 1'b0;
			regulation_q <= 1'b0;
			dir_down_q <= 1'b0;
			order_user_q <= 1'b0;
			count_q <= `LWS_COUNT_RST;
			skip_q <= `LWS_SKIP_RST;
			vmode_q <= `LWS_M_SETTING_A;
			cmode_q <= `LWS_M_SETTING_A;
			cur_ptr_q <= `LWS_PTR_RST;
			volt_ptr_q <= `LWS_PTR_RST;
			dwell_ptr_q <= `LWS_PTR_RST;
			rb_start_q <= `LWS_PTR_RST;
			rb_idx_q <= 4'h0;
		end
		else
		begin
			if (trig_wr)
			begin
				trig_reg_q <= hwdata[0];
				if (vmode_q == `LWS_M_TRANSIENT_SETTING)
					vmode_q <= `LWS_M_SETTING_A; // see [RL3]
				if (cmode_q == `LWS_M_TRANSIENT_SETTING)
					cmode_q <= `LWS_M_SETTING_A; // see [RL3]
			end
			else
			begin
				if (v_list)
					vmode_q <= `LWS_M_LIST;
				else if (v_fix)
					vmode_q <= `LWS_M_SETTING_A;
				else if (cmd_ev && cmd == `LWS_C_VTRANS)
					vmode_q <= `LWS_M_TRANSIENT_SETTING;
				if (c_list)
					cmode_q <= `LWS_M_LIST;
				else if (c_fix)
					cmode_q <= `LWS_M_SETTING_A;
				else if (cmd_ev && cmd == `LWS_C_CTRANS)
					cmode_q <= `LWS_M_TRANSIENT_SETTING;
			end
			if (cmd_ev && cmd == `LWS_C_SAVE)
				saved_trig_q <= trig_reg_q; // see [RL4]
			if (cmd_ev && cmd == `LWS_C_RECALL)
				trig_reg_q <= saved_trig_q; // see [RL4]
			// Trigger switches regulation; a plain control write also may
			if (do_trig)
				regulation_q <= trig_reg_q; // see [RL1]
			else if (hit(wr_q, addr_q, `LWS_A_CTRL))
				regulation_q <= hwdata[`LWS_B_REG]; // see [RL15]
			if (hit(wr_q, addr_q, `LWS_A_COUNT))
				count_q <= hwdata[7:0]; // see [RL6]
			if (hit(wr_q, addr_q, `LWS_A_SKIP))
				skip_q <= hwdata[7:0];
			if (hit(wr_q, addr_q, `LWS_A_CTRL))
			begin
				dir_down_q <= hwdata[`LWS_B_DIR];
				order_user_q <= hwdata[`LWS_B_ORDER];
			end
			if (cur_ok)
				cur_ptr_q <= cur_ptr_q + 10'h001; // see [RL17]
			if (volt_ok)
				volt_ptr_q <= volt_ptr_q + 10'h001;
			if (dwell_ok)
				dwell_ptr_q <= dwell_ptr_q + 10'h001;
			// A new start pointer restarts the 16-value window
			if (hit(wr_q, addr_q, `LWS_A_RBSTART))
			begin
				rb_start_q <= hwdata[9:0];
				rb_idx_q <= 4'h0;
			end
			else if (main_rd || dwell_rd)
				rb_idx_q <= rb_idx_q + 4'h1; // see [RL16]
			// Clear comes last so it overrides everything above
			if (do_clear)
			begin
				cur_ptr_q <= `LWS_PTR_RST; // see [RL5]
				volt_ptr_q <= `LWS_PTR_RST;
				dwell_ptr_q <= `LWS_PTR_RST;
				rb_start_q <= `LWS_PTR_RST;
				rb_idx_q <= 4'h0;
				dir_down_q <= 1'b0; // see [RL8]
				order_user_q <= 1'b0;
				count_q <= `LWS_COUNT_RST;
				skip_q <= `LWS_SKIP_RST; // see [RL10]
			end
		end
	end

	// Error counter: a new error in the same cycle as the read-clear survives
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			err_cnt_q <= 8'h00;
		else if (err_set)
			err_cnt_q <= (err_rd || err_cnt_q == 8'hff) ? (err_rd ? 8'h01 : 8'hff) :
				err_cnt_q + 8'h01;
		else if (err_rd)
			err_cnt_q <= 8'h00;
	end

	// Step sequencing
	wire at_end = dir_down_q ? (pos_q == `LWS_PTR_RST) : (pos_q == last_pos); // see [RL8]
	wire [9:0] skip_pos = ({2'b00, skip_q} < len) ? {2'b00, skip_q} : `LWS_PTR_RST;
	wire [9:0] pass_start = dir_down_q ? last_pos : skip_pos; // see [RL11]
	wire [9:0] dwell_idx = (dwell_ptr_q <= 10'h001 || pos_q >= dwell_ptr_q) ?
		`LWS_PTR_RST : pos_q; // see [RL19]
	wire all_done = (count_q != 8'h00) && ((pass_q + 8'h01) == count_q); // see [RL6]

	// Playback: STEP loads the value and dwell, HOLD counts ticks
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= S_IDLE;
			pos_q <= `LWS_PTR_RST;
			pass_q <= 8'h00;
			tick_q <= 17'h00000;
			hold_q <= `LWS_DWELL_MIN;
			setpoint_q <= 32'h00000000;
		end
		else if (stop_play)
			state_q <= S_IDLE; // output keeps its last step value
		else
		begin
			case (state_q)
				S_IDLE:
				begin
					if (start_play)
					begin
						pos_q <= dir_down_q ? last_pos : `LWS_PTR_RST; // see [RL9]
						pass_q <= 8'h00;
						state_q <= S_STEP;
					end
				end
				S_STEP:
				begin
					setpoint_q <= main_mem[pos_q];
					hold_q <= dwell_mem[dwell_idx];
					tick_q <= 17'h00000;
					state_q <= S_HOLD;
				end
				S_HOLD:
				begin
					if (tick_q != TICK_LAST)
						tick_q <= tick_q + 17'h00001; // see [RL22]
					else if (hold_q > `LWS_DWELL_MIN)
					begin
						tick_q <= 17'h00000;
						hold_q <= hold_q - 15'h0001;
					end
					else if (!at_end)
					begin
						pos_q <= dir_down_q ? pos_q - 10'h001 : pos_q + 10'h001;
						state_q <= S_STEP;
					end
					else if (all_done)
						state_q <= S_IDLE; // see [RL21]
					else
					begin
						pass_q <= pass_q + 8'h01;
						pos_q <= pass_start; // see [RL9]
						state_q <= S_STEP;
					end
				end
				default:
					state_q <= S_IDLE;
			endcase
		end
	end

	assign regulation_current = regulation_q;
	assign list_running = (state_q != S_IDLE);
	assign voltage_source_mode = vmode_q;
	assign current_source_mode = cmode_q;

	// Readback window address; beyond the list storage reads as zero
	wire [9:0] rb_addr = rb_start_q + {6'h00, rb_idx_q};
	wire rb_ok = rb_addr < LIST_DEPTH;

	// Read data mux, driven straight from flops and list storage
	always @*
	begin
		hrdata = 32'h00000000;
		case (addr_q)
			`LWS_A_TRIG:
				hrdata[0] = trig_reg_q; // see [RL2]
			`LWS_A_CTRL:
			begin
				hrdata[`LWS_B_DIR] = dir_down_q;
				hrdata[`LWS_B_ORDER] = order_user_q;
				hrdata[`LWS_B_REG] = regulation_q;
			end
			`LWS_A_COUNT:
				hrdata[7:0] = count_q; // see [RL7]
			`LWS_A_SKIP:
				hrdata[7:0] = skip_q;
			`LWS_A_RBSTART:
				hrdata[9:0] = rb_start_q;
			`LWS_A_MAINRD:
				hrdata = (rb_ok && !volt_busy) ? main_mem[rb_addr] : 32'h00000000;
			`LWS_A_DWELLRD:
				hrdata[14:0] = rb_ok ? dwell_mem[rb_addr] : 15'h0000;
			`LWS_A_POINTS:
			begin
				hrdata[9:0] = cur_ptr_q; // see [RL17]
				hrdata[25:16] = dwell_ptr_q;
			end
			`LWS_A_STATUS:
			begin
				hrdata[0] = list_running;
				hrdata[1] = regulation_q;
				hrdata[3:2] = vmode_q;
				hrdata[5:4] = cmode_q;
				hrdata[25:16] = volt_ptr_q;
			end
			`LWS_A_ERR:
			begin
				hrdata[7:0] = err_cnt_q;
				hrdata[31:16] = (err_cnt_q != 8'h00) ? `LWS_ERR_CONFLICT : 16'h0000;
			end
			default:
				hrdata = 32'h00000000;
		endcase
	end

endmodule

/* File: dv/lws_checker.sv */
// Checker for the list sequencer: mode, trigger and playback relations.
// Assumes binding onto lws_list_sequencer, everything on core_clk.
`timescale 1ns/1ps
`include "lws_defs.vh"
module lws_checker
(
	input wire core_clk,
	input wire resetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata,
	input wire [31:0] setpoint_q,
	input wire regulation_current,
	input wire list_running,
	input wire [1:0] voltage_source_mode,
	input wire [1:0] current_source_mode
);
	reg wr_q;
	reg rd_q;
	reg [7:0] adr_q;
	wire cmd_w = wr_q && adr_q == `LWS_A_CMD;
	wire [3:0] cmd = hwdata[3:0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Mark data phases of taken transfers
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			adr_q <= 8'h00;
		end
		else
		begin
			wr_q <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
			rd_q <= hsel && htrans[1] && hready && !hwrite;
			adr_q <= haddr[7:0];
		end
	end
	chk_trig_setting_a: assert property (wr_q && adr_q == `LWS_A_TRIG |=>
		voltage_source_mode != `LWS_M_TRANSIENT_SETTING && current_source_mode != `LWS_M_TRANSIENT_SETTING)
		else $error("transient mode kept after trigger mode write");
	chk_trig_read: assert property (rd_q && adr_q == `LWS_A_TRIG |-> hrdata[31:1] == 31'h0)
		else $error("trigger mode read not 0 or 1");
	chk_reg_cause: assert property ($changed(regulation_current) |-> $past(wr_q))
		else $error("regulation changed without a write");
	chk_ctrl_reg: assert property (wr_q && adr_q == `LWS_A_CTRL |=>
		regulation_current == $past(hwdata[2])) else $error("regulation select not taken");
	chk_halt_stop: assert property (cmd_w && cmd == `LWS_C_HALT |-> ##[1:2] !list_running)
		else $error("halt did not stop playback");
	chk_clear_stop: assert property (cmd_w && cmd == `LWS_C_CLEAR |-> ##[1:2] !list_running)
		else $error("clear did not stop playback");
	chk_setting_a_stop: assert property (cmd_w && cmd == `LWS_C_VFIX |-> ##[1:2]
		(!list_running && voltage_source_mode == `LWS_M_SETTING_A)) else $error("setting_a did not stop");
	chk_start_src: assert property ($rose(list_running) |->
		($past(cmd_w) && $past(cmd) inside {`LWS_C_VLIST, `LWS_C_CLIST}) ||
		($past(cmd_w, 2) && $past(cmd, 2) inside {`LWS_C_VLIST, `LWS_C_CLIST}))
		else $error("playback started without a start command");
	chk_idle_hold: assert property (!list_running && !$past(list_running) |-> $stable(setpoint_q))
		else $error("setpoint moved while idle");
	chk_step_min: assert property (list_running && $changed(setpoint_q) |=> $stable(setpoint_q) [*4])
		else $error("step shorter than one dwell tick");
endmodule
bind lws_list_sequencer lws_checker u_chk (.*);

/* File: dv/lws_host.sv */
// Host model: single AHB-Lite master, one whole word per access.
// Assumes the slave's hreadyout comes back as hready.
`timescale 1ns/1ps
module lws_host
(
	input wire core_clk,
	input wire hready,
	input wire [31:0] hrdata,
	output reg hsel,
	output reg [31:0] haddr,
	output reg [1:0] htrans,
	output reg hwrite,
	output reg [2:0] hsize,
	output reg [31:0] hwdata,
	output reg hung
);
	// Bus idle from time zero
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hung = 1'b0;
	end
	// Wait for hready at a rising edge; a stuck slave raises hung
	task wait_rdy;
		integer n;
	begin
		n = 0;
		@(posedge core_clk);
		while (hready !== 1'b1 && n < 64)
		begin
			@(posedge core_clk);
			n = n + 1;
		end
		if (n == 64)
			hung = 1'b1;
	end
	endtask
	// One value per access keeps each command short enough for the input buffer
	task xfer(input [7:0] a, input w, input [31:0] d, output [31:0] r);
	begin
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		r = hrdata;
	end
	endtask
endmodule

/* File: dv/tb_list_waveform_sequencer.sv */
// Testbench for the list sequencer: registers, trigger mode, list playback.
// Assumes the host model as master and a 4-cycle dwell tick for speed.
`timescale 1ns/1ps
`include "lws_defs.vh"
module tb_list_waveform_sequencer;
	reg core_clk;
	reg resetn;
	wire hsel, hwrite, hreadyout, hresp, hung, regulation_current, list_running;
	wire [31:0] haddr, hwdata, hrdata, setpoint_q;
	wire [1:0] htrans, voltage_source_mode, current_source_mode;
	wire [2:0] hsize;
	wire hready = hreadyout;
	reg [31:0] rv, last;
	reg run_d = 1'b0;
	reg [31:0] seen[$];
	integer gap[$];
	integer failures = 0, compares = 0, cyc = 0, t0 = 0, i;
	lws_host h (.*);
	lws_list_sequencer #(.TICK_CYC(4)) dut (.*);
	task stop_test;
	begin
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	task cmp(input [31:0] got, input [31:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [7:0] a, input [31:0] d);
	begin
		h.xfer(a, 1'b1, d, rv);
		if (hung !== 1'b0)
		begin
			failures = failures + 1;
			stop_test;
		end
	end
	endtask
	task rdc(input [7:0] a, input [31:0] e);
	begin
		h.xfer(a, 1'b0, 32'h0, rv);
		if (hung !== 1'b0)
		begin
			failures = failures + 1;
			stop_test;
		end
		cmp(rv, e);
	end
	endtask
	// Run the current list and compare steps, spacing and final value
	task play(input [31:0] ctrl, input [31:0] e[]);
	begin
		wr(`LWS_A_CTRL, ctrl);
		wr(`LWS_A_COUNT, 32'h2);
		seen.delete();
		gap.delete();
		last = 32'hx;
		wr(`LWS_A_CMD, 32'h5);
		@(posedge core_clk);
		cmp(list_running, 1'b1);
		for (i = 0; i < 600 && list_running !== 1'b0; i = i + 1)
			@(posedge core_clk);
		if (i == 600)
		begin
			failures = failures + 1;
			stop_test;
		end
		cmp(seen.size(), e.size());
		for (i = 0; i < e.size(); i = i + 1)
			cmp(seen[i], e[i]);
		for (i = 1; i < gap.size(); i = i + 1)
			cmp(gap[i], 5);
		cmp(setpoint_q, e[e.size() - 1]);
	end
	endtask
	// Log each new setpoint and its spacing; values are the pre-edge ones.
	// The first running cycle still shows the previous run's value, so skip it
	always @(posedge core_clk)
	begin
		cyc = cyc + 1;
		if (list_running === 1'b1 && run_d === 1'b1 && setpoint_q !== last)
		begin
			seen.push_back(setpoint_q);
			gap.push_back(cyc - t0);
			t0 = cyc;
			last = setpoint_q;
		end
		run_d = list_running;
	end
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		resetn = 1'b0;
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		rdc(`LWS_A_COUNT, 32'h1);
		rdc(`LWS_A_CTRL, 32'h0);
		cmp(hresp, 32'h0);
		wr(`LWS_A_COUNT, 32'hff);
		rdc(`LWS_A_COUNT, 32'hff);
		wr(`LWS_A_SKIP, 32'h7);
		wr(`LWS_A_CTRL, 32'h3);
		wr(`LWS_A_CMD, 32'h1);
		rdc(`LWS_A_COUNT, 32'h1);
		rdc(`LWS_A_SKIP, 32'h0);
		rdc(`LWS_A_CTRL, 32'h0);
		wr(`LWS_A_CMD, 32'h8);
		wr(`LWS_A_CMD, 32'h9);
		rdc(`LWS_A_STATUS, 32'h28);
		wr(`LWS_A_TRIG, 32'h1);
		rdc(`LWS_A_STATUS, 32'h0);
		rdc(`LWS_A_TRIG, 32'h1);
		wr(`LWS_A_CMD, 32'h2);
		rdc(`LWS_A_STATUS, 32'h2);
		wr(`LWS_A_CMD, 32'ha);
		wr(`LWS_A_TRIG, 32'h0);
		wr(`LWS_A_CMD, 32'h2);
		rdc(`LWS_A_STATUS, 32'h0);
		wr(`LWS_A_CMD, 32'hb);
		rdc(`LWS_A_TRIG, 32'h1);
		wr(`LWS_A_CTRL, 32'h4);
		for (i = 1; i < 4; i = i + 1)
			wr(`LWS_A_CUR, 32'h10 * i);
		rdc(`LWS_A_POINTS, 32'h3);
		wr(`LWS_A_DWELL, 32'h1);
		rdc(`LWS_A_POINTS, 32'h10003);
		wr(`LWS_A_RBSTART, 32'h1);
		rdc(`LWS_A_MAINRD, 32'h20);
		rdc(`LWS_A_MAINRD, 32'h30);
		wr(`LWS_A_RBSTART, 32'h0);
		rdc(`LWS_A_DWELLRD, 32'h1);
		rdc(8'h3c, 32'h0);
		wr(`LWS_A_SKIP, 32'h1);
		play(32'h4, '{32'h10, 32'h20, 32'h30, 32'h20, 32'h30});
		play(32'h5, '{32'h30, 32'h20, 32'h10, 32'h30, 32'h20, 32'h10});
		wr(`LWS_A_CTRL, 32'h4);
		wr(`LWS_A_COUNT, 32'h0);
		wr(`LWS_A_CMD, 32'h5);
		repeat (100) @(posedge core_clk);
		cmp(list_running, 1'b1);
		wr(`LWS_A_CMD, 32'h3);
		repeat (2) @(posedge core_clk);
		cmp(list_running, 1'b0);
		// Endless runs stopped by the setting_a commands of either source
		wr(`LWS_A_CMD, 32'h4);
		repeat (20) @(posedge core_clk);
		cmp(list_running, 1'b1);
		wr(`LWS_A_CMD, 32'h6);
		repeat (2) @(posedge core_clk);
		cmp(list_running, 1'b0);
		rdc(`LWS_A_STATUS, 32'h12);
		wr(`LWS_A_CMD, 32'h5);
		repeat (20) @(posedge core_clk);
		cmp(list_running, 1'b1);
		wr(`LWS_A_CMD, 32'h7);
		repeat (2) @(posedge core_clk);
		cmp(list_running, 1'b0);
		wr(`LWS_A_CMD, 32'h1);
		wr(`LWS_A_CTRL, 32'h0);
		wr(`LWS_A_VOLT, 32'h5);
		wr(`LWS_A_CUR, 32'h7);
		rdc(`LWS_A_ERR, 32'hff230001);
		rdc(`LWS_A_POINTS, 32'h0);
		rdc(`LWS_A_ERR, 32'hff230001);
		rdc(`LWS_A_MAINRD, 32'h0);
		rdc(`LWS_A_ERR, 32'hff230001);
		// Dwell limits: 0.0005 s is one tick, 10 s is 20000 ticks
		wr(`LWS_A_DWELL, 32'h0);
		wr(`LWS_A_DWELL, 32'h30000);
		wr(`LWS_A_RBSTART, 32'h0);
		rdc(`LWS_A_DWELLRD, 32'h1);
		rdc(`LWS_A_DWELLRD, 32'h4e20);
		stop_test;
	end
endmodule
